// ===== dv/bdp_pci_agent.sv
`default_nettype none

module bdp_pci_agent (
    // Clock
    input wire logic clk,
    // Data phase toward the bridge
    output logic dp_valid,
    output bdp_pkg::bdp_kind_e kind,
    output logic dir,
    output logic fwd_bad,
    output logic [31:0] ad,
    output logic [3:0] cbe_n,
    output logic par,
    // Parity error drive, high when released (pull-up)
    output logic perr_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        dp_valid = 1'b0;
        kind = bdp_pkg::KIND_READ;
        dir = 1'b0;
        fwd_bad = 1'b0;
        ad = 32'h5a5a_0ff0;
        cbe_n = 4'h3;
        par = 1'b0;
        perr_n = 1'b1;
    end

    // One data phase; bad corrupts parity, perr reports a fault
    task automatic phase(input bdp_pkg::bdp_kind_e k, input logic d,
        input logic fb, input logic bad, input logic perr);
        logic [31:0] data;
        data = ~ad ^ 32'h0001_0203;
        @(posedge clk);
        dp_valid <= 1'b1;
        kind <= k;
        dir <= d;
        fwd_bad <= fb;
        ad <= data;
        cbe_n <= data[7:4];
        @(posedge clk);
        dp_valid <= 1'b0;
        // Released lines show the inverse, not a stale value
        ad <= ~data;
        cbe_n <= ~data[7:4];
        par <= ^{data, data[7:4]} ^ bad;
        @(posedge clk);
        par <= ~(^{data, data[7:4]} ^ bad);
        perr_n <= ~perr;
        @(posedge clk);
        perr_n <= 1'b1;
    endtask
endmodule // bdp_pci_agent

`default_nettype wire

// ===== dv/bridge_data_parity_error_reporting_tb.sv
`default_nettype none

module bridge_data_parity_error_reporting_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk;
    logic rst;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_we;
    logic reg_re;
    logic [31:0] reg_rdata;
    logic p_valid, p_dir, p_fb, p_par, p_drv_n, p_out_n, p_oe_n;
    logic s_valid, s_dir, s_fb, s_par, s_drv_n, s_out_n, s_oe_n;
    logic serr_out_n, serr_oe_n, p_pin_n, s_pin_n;
    bdp_pkg::bdp_kind_e p_kind, s_kind;
    logic [31:0] p_ad, s_ad;
    logic [3:0] p_cbe_n, s_cbe_n;
    int fail_count = 0;
    int n_compared = 0;

    // Pins with pull-ups: low if either party drives low
    assign p_pin_n = (p_oe_n | p_out_n) & p_drv_n;
    assign s_pin_n = (s_oe_n | s_out_n) & s_drv_n;

    bdp_pci_agent i_pri (.clk(sys_clk), .dp_valid(p_valid), .kind(p_kind),
        .dir(p_dir), .fwd_bad(p_fb), .ad(p_ad), .cbe_n(p_cbe_n),
        .par(p_par), .perr_n(p_drv_n));
    bdp_pci_agent i_sec (.clk(sys_clk), .dp_valid(s_valid), .kind(s_kind),
        .dir(s_dir), .fwd_bad(s_fb), .ad(s_ad), .cbe_n(s_cbe_n),
        .par(s_par), .perr_n(s_drv_n));

    bdp_parity_err i_dut (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata),
        .pri_dp_valid(p_valid), .pri_kind(p_kind), .pri_dir(p_dir),
        .pri_fwd_bad(p_fb), .pri_ad(p_ad), .pri_cbe_n(p_cbe_n),
        .pri_par(p_par), .sec_dp_valid(s_valid), .sec_kind(s_kind),
        .sec_dir(s_dir), .sec_fwd_bad(s_fb), .sec_ad(s_ad),
        .sec_cbe_n(s_cbe_n), .sec_par(s_par),
        .primary_parity_err_n_in(p_pin_n),
        .primary_parity_err_n_out(p_out_n),
        .primary_parity_err_n_oe_n(p_oe_n),
        .secondary_parity_err_n_in(s_pin_n),
        .secondary_parity_err_n_out(s_out_n),
        .secondary_parity_err_n_oe_n(s_oe_n),
        .primary_system_err_n_out(serr_out_n),
        .primary_system_err_n_oe_n(serr_oe_n));

    task automatic check(input string what, input logic [31:0] e,
        input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_we <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        #1;
        check("register read", e, reg_rdata);
    endtask

    // One error case: sec picks the bus, the agent plays the far party
    task automatic run_case(input logic [2:0] cfg, input logic sec,
        input logic d, input logic fb, input bdp_pkg::bdp_kind_e k);
        logic mst, rcv, dly;
        logic [2:0] e_pin, e_sys, g_pin, g_sys;
        logic [3:0] e_oe, g_oe;
        mst = d ^ sec;
        rcv = (k == bdp_pkg::KIND_READ) ? mst : !mst;
        dly = k == bdp_pkg::KIND_DELAYED;
        e_pin[0] = !(!sec & rcv & cfg[0]);
        e_pin[1] = !(sec & rcv & cfg[2]);
        e_pin[2] = !(dly & (sec ^ d) & cfg[0] & cfg[2]);
        e_sys[0] = 1'b1;
        e_sys[1] = !(k == bdp_pkg::KIND_POSTED & mst & !fb & &cfg);
        e_sys[2] = e_sys[1];
        // Enables low in the pulse cycle and one more; relays one cycle on
        e_oe[1:0] = e_pin[1:0];
        e_oe[2] = e_pin[0] & (!sec | e_pin[2]);
        e_oe[3] = e_pin[1] & (sec | e_pin[2]);
        fork
            if (sec) i_sec.phase(k, d, fb, rcv, !rcv);
            else i_pri.phase(k, d, fb, rcv, !rcv);
            begin
                repeat (3) @(posedge sys_clk);
                #1;
                g_pin[1:0] = {s_out_n, p_out_n};
                g_sys[0] = serr_out_n;
                g_oe[1:0] = {s_oe_n, p_oe_n};
                @(posedge sys_clk);
                #1;
                g_pin[2] = sec ? p_out_n : s_out_n;
                g_sys[2:1] = {serr_oe_n, serr_out_n};
                g_oe[3:2] = {s_oe_n, p_oe_n};
            end
        join
        check("parity pins", 32'(e_pin), 32'(g_pin));
        check("system pin", 32'(e_sys), 32'(g_sys));
        check("parity enables", 32'(e_oe), 32'(g_oe));
        reg_read(bdp_pkg::STAT_OFS, {29'h0, !e_sys[1], sec & mst & cfg[2],
            !sec & mst & cfg[0]});
        reg_write(bdp_pkg::STAT_OFS, 32'h0000_0007);
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Whole run is about 1600 cycles
    initial begin
        #200us;
        fail_count++;
        finish_test();
    end

    initial begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_we = 1'b0;
        reg_re = 1'b0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check("pins in reset", 32'h0000_003f, {26'h0, p_out_n, p_oe_n,
            s_out_n, s_oe_n, serr_out_n, serr_oe_n});
        reg_read(bdp_pkg::STAT_OFS, 32'h0000_0000);
        reg_write(8'h08, 32'hffff_ffff);
        reg_read(8'h08, 32'h0000_0000);
        // Every enable mix against every kind, direction and bus
        for (int cfg = 0; cfg < 8; cfg++) begin
            reg_write(bdp_pkg::CTRL_OFS, 32'(cfg));
            reg_read(bdp_pkg::CTRL_OFS, 32'(cfg));
            for (int c = 0; c < 24; c++) begin
                run_case(cfg[2:0], c[0], c[1], c[2],
                    bdp_pkg::bdp_kind_e'(c[4:3]));
            end
        end
        finish_test();
    end
endmodule // bridge_data_parity_error_reporting_tb

`default_nettype wire

// ===== src/bdp_parity_err.sv
// Notes on behaviour
// - Secondary master parity bit only as secondary master
// - Secondary master parity bit needs secondary response
// - Set on sampled secondary error or own detection
// - Downstream secondary-bus errors only; never upstream
// - Primary error output: write target, read initiator
// - Primary error output needs primary response enable
// - Downstream delayed write: relay secondary error upstream
// - Secondary error output: write target, read initiator
// - Secondary error output needs secondary response enable
// - Upstream delayed write: relay primary error downstream
// - Posted write error on target bus raises system error
// - Not when bridge flagged it on initiator bus
// - System error needs both response enables
// - System error needs system error enable
// - Never system error for reads or delayed writes
// - Primary master parity bit only as primary master
// - System error also sets signaled system error bit
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`default_nettype none

module bdp_parity_err (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    // Primary bus data phase
    input wire logic pri_dp_valid,
    input wire bdp_pkg::bdp_kind_e pri_kind,
    input wire logic pri_dir,
    input wire logic pri_fwd_bad,
    input wire logic [31:0] pri_ad,
    input wire logic [3:0] pri_cbe_n,
    input wire logic pri_par,
    // Secondary bus data phase
    input wire logic sec_dp_valid,
    input wire bdp_pkg::bdp_kind_e sec_kind,
    input wire logic sec_dir,
    input wire logic sec_fwd_bad,
    input wire logic [31:0] sec_ad,
    input wire logic [3:0] sec_cbe_n,
    input wire logic sec_par,
    // Primary parity error pin
    input wire logic primary_parity_err_n_in,
    output logic primary_parity_err_n_out,
    output logic primary_parity_err_n_oe_n,
    // Secondary parity error pin
    input wire logic secondary_parity_err_n_in,
    output logic secondary_parity_err_n_out,
    output logic secondary_parity_err_n_oe_n,
    // Primary system error pin, open drain
    output logic primary_system_err_n_out,
    output logic primary_system_err_n_oe_n
);

    typedef struct packed {
        bdp_pkg::bdp_ctx_s p1;
        bdp_pkg::bdp_ctx_s p2;
        bdp_pkg::bdp_ctx_s s1;
        bdp_pkg::bdp_ctx_s s2;
        logic per_pri;
        logic per_sec;
        logic serr_en;
        logic mdpd_pri;
        logic mdpd_sec;
        logic sig_serr;
        logic p_perr_n;
        logic p_perr_oe_n;
        logic s_perr_n;
        logic s_perr_oe_n;
        logic serr_n;
        logic serr_oe_n;
        logic [31:0] rdata;
    } bdp_state_s;

    bdp_state_s state_q;
    bdp_state_s state_d;

    logic p_rx;
    logic s_rx;
    logic p_det;
    logic s_det;
    logic p_seen;
    logic s_seen;
    logic p_fire;
    logic s_fire;
    logic serr_fire;
    logic mdpd_pri_set;
    logic mdpd_sec_set;
    logic stat_wr;
    logic ctrl_wr;

    always_comb begin
        state_d = state_q;
        // Stage one: the data phase; parity for it arrives next cycle
        state_d.p1.valid = pri_dp_valid;
        state_d.p1.kind = pri_kind;
        state_d.p1.dir = pri_dir;
        state_d.p1.fwd_bad = pri_fwd_bad;
        state_d.p1.par = ^{pri_ad, pri_cbe_n};
        state_d.s1.valid = sec_dp_valid;
        state_d.s1.kind = sec_kind;
        state_d.s1.dir = sec_dir;
        state_d.s1.fwd_bad = sec_fwd_bad;
        state_d.s1.par = ^{sec_ad, sec_cbe_n};
        // Stage two: the cycle in which the receiver's error pin answers
        state_d.p2 = state_q.p1;
        state_d.s2 = state_q.s1;

        // Bridge receives data: write target or read initiator
        p_rx = (state_q.p1.dir == bdp_pkg::DIR_UP) ?
            (state_q.p1.kind == bdp_pkg::KIND_READ) :
            (state_q.p1.kind != bdp_pkg::KIND_READ);
        s_rx = (state_q.s1.dir == bdp_pkg::DIR_DOWN) ?
            (state_q.s1.kind == bdp_pkg::KIND_READ) :
            (state_q.s1.kind != bdp_pkg::KIND_READ);
        p_det = state_q.p1.valid && p_rx
            && (pri_par != state_q.p1.par);
        s_det = state_q.s1.valid && s_rx
            && (sec_par != state_q.s1.par);

        // Error pin of the far receiver, only where the bridge drove data
        p_seen = state_q.p2.valid && !primary_parity_err_n_in
            && ((state_q.p2.dir == bdp_pkg::DIR_UP) ?
                (state_q.p2.kind != bdp_pkg::KIND_READ) :
                (state_q.p2.kind == bdp_pkg::KIND_READ));
        s_seen = state_q.s2.valid && !secondary_parity_err_n_in
            && ((state_q.s2.dir == bdp_pkg::DIR_DOWN) ?
                (state_q.s2.kind != bdp_pkg::KIND_READ) :
                (state_q.s2.kind == bdp_pkg::KIND_READ));

        mdpd_pri_set = state_q.per_pri
            && ((p_det && state_q.p1.dir == bdp_pkg::DIR_UP)
                || (p_seen && state_q.p2.dir == bdp_pkg::DIR_UP));
        mdpd_sec_set = state_q.per_sec
            && ((s_det && state_q.s1.dir == bdp_pkg::DIR_DOWN)
                || (s_seen && state_q.s2.dir == bdp_pkg::DIR_DOWN));

        p_fire = state_q.per_pri
            && (p_det
                || (s_seen && state_q.per_sec
                    && state_q.s2.dir == bdp_pkg::DIR_DOWN
                    && state_q.s2.kind == bdp_pkg::KIND_DELAYED));
        s_fire = state_q.per_sec
            && (s_det
                || (p_seen && state_q.per_pri
                    && state_q.p2.dir == bdp_pkg::DIR_UP
                    && state_q.p2.kind == bdp_pkg::KIND_DELAYED));

        serr_fire = state_q.serr_en
            && state_q.per_pri && state_q.per_sec
            && ((p_seen && state_q.p2.dir == bdp_pkg::DIR_UP
                    && state_q.p2.kind == bdp_pkg::KIND_POSTED
                    && !state_q.p2.fwd_bad)
                || (s_seen && state_q.s2.dir == bdp_pkg::DIR_DOWN
                    && state_q.s2.kind == bdp_pkg::KIND_POSTED
                    && !state_q.s2.fwd_bad));

        // Pins: low for one cycle, then driven high one cycle before release
        state_d.p_perr_n = !p_fire;
        state_d.p_perr_oe_n = !(p_fire || !state_q.p_perr_n);
        state_d.s_perr_n = !s_fire;
        state_d.s_perr_oe_n = !(s_fire || !state_q.s_perr_n);
        // Open drain: never driven high
        state_d.serr_n = !serr_fire;
        state_d.serr_oe_n = !serr_fire;

        // Registers; a set in the clearing cycle wins
        ctrl_wr = reg_we && (reg_addr == bdp_pkg::CTRL_OFS);
        stat_wr = reg_we && (reg_addr == bdp_pkg::STAT_OFS);
        if (ctrl_wr) begin
            state_d.per_pri = reg_wdata[bdp_pkg::CTRL_PER_PRI_BIT];
            state_d.serr_en = reg_wdata[bdp_pkg::CTRL_SERR_EN_BIT];
            state_d.per_sec = reg_wdata[bdp_pkg::CTRL_PER_SEC_BIT];
        end
        state_d.mdpd_pri = mdpd_pri_set || (state_q.mdpd_pri
            && !(stat_wr && reg_wdata[bdp_pkg::STAT_MDPD_PRI_BIT]));
        state_d.mdpd_sec = mdpd_sec_set || (state_q.mdpd_sec
            && !(stat_wr && reg_wdata[bdp_pkg::STAT_MDPD_SEC_BIT]));
        state_d.sig_serr = serr_fire || (state_q.sig_serr
            && !(stat_wr && reg_wdata[bdp_pkg::STAT_SIG_SERR_BIT]));

        // Read data stand for one cycle only; unmapped reads give zero
        state_d.rdata = bdp_pkg::RDATA_IDLE;
        if (reg_re) begin
            if (reg_addr == bdp_pkg::CTRL_OFS) begin
                state_d.rdata[bdp_pkg::CTRL_PER_PRI_BIT] = state_q.per_pri;
                state_d.rdata[bdp_pkg::CTRL_SERR_EN_BIT] = state_q.serr_en;
                state_d.rdata[bdp_pkg::CTRL_PER_SEC_BIT] = state_q.per_sec;
            end else if (reg_addr == bdp_pkg::STAT_OFS) begin
                state_d.rdata[bdp_pkg::STAT_MDPD_PRI_BIT] = state_q.mdpd_pri;
                state_d.rdata[bdp_pkg::STAT_MDPD_SEC_BIT] = state_q.mdpd_sec;
                state_d.rdata[bdp_pkg::STAT_SIG_SERR_BIT] = state_q.sig_serr;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
            state_q.per_pri <= bdp_pkg::CTRL_RST;
            state_q.per_sec <= bdp_pkg::CTRL_RST;
            state_q.serr_en <= bdp_pkg::CTRL_RST;
            state_q.mdpd_pri <= bdp_pkg::STAT_RST;
            state_q.mdpd_sec <= bdp_pkg::STAT_RST;
            state_q.sig_serr <= bdp_pkg::STAT_RST;
            state_q.p_perr_n <= bdp_pkg::PIN_IDLE_N;
            state_q.p_perr_oe_n <= bdp_pkg::PIN_IDLE_N;
            state_q.s_perr_n <= bdp_pkg::PIN_IDLE_N;
            state_q.s_perr_oe_n <= bdp_pkg::PIN_IDLE_N;
            state_q.serr_n <= bdp_pkg::PIN_IDLE_N;
            state_q.serr_oe_n <= bdp_pkg::PIN_IDLE_N;
            state_q.rdata <= bdp_pkg::RDATA_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;
    assign primary_parity_err_n_out = state_q.p_perr_n;
    assign primary_parity_err_n_oe_n = state_q.p_perr_oe_n;
    assign secondary_parity_err_n_out = state_q.s_perr_n;
    assign secondary_parity_err_n_oe_n = state_q.s_perr_oe_n;
    assign primary_system_err_n_out = state_q.serr_n;
    assign primary_system_err_n_oe_n = state_q.serr_oe_n;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Bad data received upstream on the primary read two cycles earlier
    sequence pri_bad_read_s;
        pri_dp_valid && pri_dir == bdp_pkg::DIR_UP
            && pri_kind == bdp_pkg::KIND_READ && state_q.per_pri
        ##1 (pri_par != state_q.p1.par) && state_q.per_pri;
    endsequence

    sequence sec_bad_write_s;
        sec_dp_valid && sec_dir == bdp_pkg::DIR_UP
            && sec_kind != bdp_pkg::KIND_READ && state_q.per_sec
        ##1 (sec_par != state_q.s1.par) && state_q.per_sec;
    endsequence

    pri_perr_time_a: assert property (
        pri_bad_read_s |=> !primary_parity_err_n_out
            && !primary_parity_err_n_oe_n ##1 primary_parity_err_n_out)
        else $error("primary parity error not driven for bad read");

    sec_perr_time_a: assert property (
        sec_bad_write_s |=> !secondary_parity_err_n_out
            ##1 secondary_parity_err_n_out && !secondary_parity_err_n_oe_n)
        else $error("secondary parity error not driven for bad write");

    pri_perr_en_a: assert property (
        $fell(primary_parity_err_n_out) |-> $past(state_q.per_pri))
        else $error("primary parity error without response enable");

    sec_perr_en_a: assert property (
        !secondary_parity_err_n_out |-> $past(state_q.per_sec))
        else $error("secondary parity error without response enable");

    dw_down_relay_a: assert property (
        s_seen && state_q.s2.dir == bdp_pkg::DIR_DOWN
            && state_q.s2.kind == bdp_pkg::KIND_DELAYED
            && state_q.per_pri && state_q.per_sec
        |=> !primary_parity_err_n_out)
        else $error("delayed write error not relayed to primary");

    dw_up_relay_a: assert property (
        p_seen && state_q.p2.dir == bdp_pkg::DIR_UP
            && state_q.p2.kind == bdp_pkg::KIND_DELAYED
            && state_q.per_pri && state_q.per_sec
        |=> !secondary_parity_err_n_out)
        else $error("delayed write error not relayed to secondary");

    sec_mdpd_set_a: assert property (
        s_det && state_q.s1.dir == bdp_pkg::DIR_DOWN && state_q.per_sec
        |=> state_q.mdpd_sec [*2])
        else $error("secondary master parity bit not set");

    sec_mdpd_cause_a: assert property (
        $rose(state_q.mdpd_sec) |-> $past(state_q.per_sec
            && ((state_q.s1.valid && state_q.s1.dir == bdp_pkg::DIR_DOWN)
             || (state_q.s2.valid && state_q.s2.dir == bdp_pkg::DIR_DOWN))))
        else $error("secondary master parity bit set without cause");

    pri_mdpd_cause_a: assert property (
        $rose(state_q.mdpd_pri) |-> $past(state_q.per_pri
            && ((state_q.p1.valid && state_q.p1.dir == bdp_pkg::DIR_UP)
             || (state_q.p2.valid && state_q.p2.dir == bdp_pkg::DIR_UP))))
        else $error("primary master parity bit set without cause");

    serr_enable_a: assert property (
        !primary_system_err_n_out |-> $past(state_q.serr_en
            && state_q.per_pri && state_q.per_sec))
        else $error("system error without enables");

    serr_posted_a: assert property (
        !primary_system_err_n_out |-> $past(
            (p_seen && state_q.p2.kind == bdp_pkg::KIND_POSTED
                && !state_q.p2.fwd_bad)
            || (s_seen && state_q.s2.kind == bdp_pkg::KIND_POSTED
                && !state_q.s2.fwd_bad)))
        else $error("system error for a non posted or flagged phase");

    serr_status_a: assert property (
        $fell(primary_system_err_n_out) |-> state_q.sig_serr
            ##1 state_q.sig_serr)
        else $error("signaled system error bit missing");

    sticky_hold_a: assert property (
        state_q.mdpd_pri && !(stat_wr
            && reg_wdata[bdp_pkg::STAT_MDPD_PRI_BIT])
        |=> state_q.mdpd_pri)
        else $error("primary master parity bit lost");

    pri_mdpd_set_a: assert property (
        p_det && state_q.p1.dir == bdp_pkg::DIR_UP && state_q.per_pri
        |=> state_q.mdpd_pri)
        else $error("primary master parity bit not set");

    // Target bus reports a posted write the bridge passed on clean
    sequence posted_target_err_s;
        state_q.serr_en && state_q.per_pri && state_q.per_sec
            && ((p_seen && state_q.p2.dir == bdp_pkg::DIR_UP
                    && state_q.p2.kind == bdp_pkg::KIND_POSTED
                    && !state_q.p2.fwd_bad)
                || (s_seen && state_q.s2.dir == bdp_pkg::DIR_DOWN
                    && state_q.s2.kind == bdp_pkg::KIND_POSTED
                    && !state_q.s2.fwd_bad));
    endsequence

    serr_pulse_a: assert property (
        posted_target_err_s |=> !primary_system_err_n_out
            && !primary_system_err_n_oe_n ##1 primary_system_err_n_oe_n)
        else $error("system error not pulsed for posted write");

    // Driving high before release keeps the pull-up from a slow rise
    pri_perr_oe_a: assert property (
        $rose(primary_parity_err_n_out) |-> !primary_parity_err_n_oe_n)
        else $error("primary parity error released while low");

    sec_perr_oe_a: assert property (
        $rose(secondary_parity_err_n_out) |-> !secondary_parity_err_n_oe_n)
        else $error("secondary parity error released while low");

endmodule // bdp_parity_err

`default_nettype wire

// ===== src/bdp_pkg.sv
`default_nettype none

package bdp_pkg;

    // Kind of the transaction that owns a data phase
    typedef enum logic [1:0] {
        KIND_READ,
        KIND_POSTED,
        KIND_DELAYED
    } bdp_kind_e;

    // Direction of the transaction that owns a data phase
    localparam logic DIR_DOWN = 1'b0;
    localparam logic DIR_UP = 1'b1;

    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;

    // Control register fields
    localparam int CTRL_PER_PRI_BIT = 0;
    localparam int CTRL_SERR_EN_BIT = 1;
    localparam int CTRL_PER_SEC_BIT = 2;

    // Status register fields, write one to clear
    localparam int STAT_MDPD_PRI_BIT = 0;
    localparam int STAT_MDPD_SEC_BIT = 1;
    localparam int STAT_SIG_SERR_BIT = 2;

    // Reset values
    localparam logic CTRL_RST = 1'b0;
    localparam logic STAT_RST = 1'b0;
    localparam logic PIN_IDLE_N = 1'b1;
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

    // Per-bus pipeline stage of one data phase
    typedef struct packed {
        logic valid;
        bdp_kind_e kind;
        logic dir;
        logic fwd_bad;
        logic par;
    } bdp_ctx_s;

endpackage

`default_nettype wire
